// [verification/ebi_mem_model.sv]
`timescale 1ns/10ps
module ebi_mem_model (
	// Clock
	input  wire logic        clk,
	// Bus pins as the memory sees them
	input  wire logic        strobe_n,
	input  wire logic        io_strobe_n,
	input  wire logic        ctrl_oe_n,
	input  wire logic        rw,
	input  wire logic [23:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wdata_oe_n,
	// Answers
	output logic      [31:0] rdata,
	output logic             ready_n,
	// Scenario control
	input  wire logic        slow
);
	logic [31:0] mem [0:63];
	logic [31:0] iom [0:63];
	logic [31:0] last     = 32'h0;
	logic [1:0]  hold_cnt = 2'h0;
	logic [1:0]  low_cnt  = 2'h0;
	logic        sel;

	// A floated strobe is pulled high, so a held port selects nothing.
	assign sel = (!ctrl_oe_n && !strobe_n) || !io_strobe_n;
	// A slow device keeps ready inactive for its first three strobe cycles.
	assign ready_n = slow && (low_cnt != 2'h3);
	// The controller's write drive wins; a released line shows the last read word, then toggles.
	assign rdata = !wdata_oe_n ? wdata : (sel && rw) ? (io_strobe_n ? mem[addr[5:0]] : iom[addr[5:0]]) : last;

	// Memory and I/O are separate spaces; read data is held four cycles for the synchroniser, then toggles.
	always_ff @(posedge clk)
	begin
		if (sel && !rw && io_strobe_n)
			mem[addr[5:0]] <= wdata;
		if (sel && !rw && !io_strobe_n)
			iom[addr[5:0]] <= wdata;
		if (sel && rw)
			hold_cnt <= 2'h3;
		else if (hold_cnt != 2'h0)
			hold_cnt <= hold_cnt - 2'h1;
		last <= (sel && rw) ? rdata : (hold_cnt != 2'h0) ? last : ~last;
		low_cnt <= !sel ? 2'h0 : (low_cnt == 2'h3) ? low_cnt : low_cnt + 2'h1;
	end
endmodule : ebi_mem_model

// [verification/external_bus_interface_tb_top.sv]
`timescale 1ns/10ps
module external_bus_interface_tb_top;
	localparam logic [23:0] PCR = ebi_pkg::EBI_PRIM_CTRL_ADDR;
	localparam logic [23:0] XCR = ebi_pkg::EBI_EXP_CTRL_ADDR;
	// Wait table: count, mode, slow device, lower bound only, cycles to read data.
	localparam logic [10:0] WT [7] = '{{3'h3, 2'h1, 1'h0, 1'h0, 4'h5}, {3'h7, 2'h1, 1'h0, 1'h0, 4'h9},
		{3'h7, 2'h0, 1'h0, 1'h0, 4'h2}, {3'h7, 2'h2, 1'h0, 1'h0, 4'h2}, {3'h3, 2'h3, 1'h0, 1'h0, 4'h5},
		{3'h2, 2'h2, 1'h1, 1'h0, 4'h4}, {3'h0, 2'h0, 1'h1, 1'h1, 4'h5}};
	logic                    clk = 1'b0;
	logic                    reset, reg_wr, hold_req_n, chk_wr, slow_p, ok;
	logic [23:0]             reg_addr, prim_addr;
	logic [31:0]             reg_wdata, reg_rdata, prim_data_out, prim_data_in, exp_data_out, exp_data_in, q0, q1;
	ebi_pkg::ebi_req_t [1:0] req;
	logic [1:0]              req_ready, rd_valid;
	logic [1:0][31:0]        rd_data;
	logic                    primary_access_strobe_n, prim_rw, prim_data_oe_n, prim_ctrl_oe_n, prim_ready_n;
	logic                    expansion_memory_strobe_n, expansion_io_strobe_n, exp_rw, exp_data_oe_n;
	logic                    expansion_ready_n, bus_release_ack_n, held_status;
	logic [12:0]             exp_addr;
	int                      n_errors = 0, n_tests = 0, l0, l1;

	ebi_core i_dut (
		.clk, .reset, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .req, .req_ready, .rd_valid, .rd_data,
		.primary_access_strobe_n, .prim_rw, .prim_addr, .prim_data_out, .prim_data_in, .prim_data_oe_n,
		.prim_ctrl_oe_n, .prim_ready_n, .expansion_memory_strobe_n, .expansion_io_strobe_n, .exp_rw,
		.exp_addr, .exp_data_out, .exp_data_in, .exp_data_oe_n, .expansion_ready_n, .hold_req_n,
		.bus_release_ack_n, .held_status
	);
	ebi_mem_model i_prim_mem (
		.clk(clk), .strobe_n(primary_access_strobe_n), .io_strobe_n(1'b1), .ctrl_oe_n(prim_ctrl_oe_n),
		.rw(prim_rw), .addr(prim_addr), .wdata(prim_data_out), .wdata_oe_n(prim_data_oe_n),
		.rdata(prim_data_in), .ready_n(prim_ready_n), .slow(slow_p)
	);
	ebi_mem_model i_exp_mem (
		.clk(clk), .strobe_n(expansion_memory_strobe_n), .io_strobe_n(expansion_io_strobe_n), .ctrl_oe_n(1'b0),
		.rw(exp_rw), .addr({11'h0, exp_addr}), .wdata(exp_data_out), .wdata_oe_n(exp_data_oe_n),
		.rdata(exp_data_in), .ready_n(expansion_ready_n), .slow(1'b0)
	);

	// Clock; the watchdog allows far more than the few hundred cycles the run needs.
	always #25 clk = ~clk;
	initial
	begin
		#1000000;
		n_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		report_and_stop();
	end

	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	// Strobe and select of one bus's memory space, packed for a single compare.
	function automatic logic [1:0] pins(input int b);
		return b ? {expansion_memory_strobe_n, exp_rw} : {primary_access_strobe_n, prim_rw};
	endfunction : pins

	task automatic reg_write(input logic [23:0] a, input logic [31:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask : reg_write

	// Read data is registered, so two edges pass before it is trusted.
	task automatic reg_check(input logic [23:0] a, input logic [31:0] e);
		reg_addr = a;
		@(posedge clk);
		@(posedge clk);
		#1;
		check_val(reg_rdata, e);
	endtask : reg_check

	// One request held until taken; a read returns its data and the negedges counted to rd_valid.
	task automatic bus_op(input int b, input logic wr, input logic io, input logic [23:0] a,
		input logic [31:0] d, output logic [31:0] q, output int lat);
		int n;
		n = 0;
		lat = 0;
		req[b] = '{1'b1, wr, io, a, d};
		@(negedge clk);
		while (req_ready[b] !== 1'b1 && n < 200) @(negedge clk) n++;
		@(posedge clk);
		#1;
		req[b].valid = 1'b0;
		if (wr && chk_wr)
		begin
			@(negedge clk);
			check_val(pins(b), 2'h2);
			@(negedge clk);
			check_val(pins(b), 2'h0);
		end
		while (!wr && rd_valid[b] !== 1'b1 && lat < 300) @(negedge clk) lat++;
		q = rd_data[b];
		// An edge always passes so the next call never raises valid in the step that lowered it.
		@(posedge clk);
		#1;
		check_val(n < 200 && lat < 300, 1'h1);
	endtask : bus_op

	task automatic wait_ack(input logic v);
		int n;
		n = 0;
		@(negedge clk);
		while (bus_release_ack_n !== v && n < 20) @(negedge clk) n++;
		check_val(bus_release_ack_n, v);
		@(posedge clk);
		#1;
	endtask : wait_ack

	// Main sequence: registers, zero-wait shapes, both buses, I/O space, wait modes, hold.
	initial
	begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_addr = PCR;
		reg_wdata = 32'h0;
		req = '0;
		hold_req_n = 1'b1;
		chk_wr = 1'b0;
		slow_p = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		reset = 1'b0;
		reg_check(PCR, 32'h000010F8);
		reg_check(XCR, 32'h000000F8);
		check_val(bus_release_ack_n, 1'h1);
		reg_write(PCR, 32'hFFFFFFFB);
		reg_check(PCR, 32'h00001FFA);
		reg_write(XCR, 32'hFFFFFFFF);
		reg_check(XCR, 32'h000000F8);
		reg_write(24'h808062, 32'hFFFFFFFF);
		reg_check(24'h808062, 32'h0);
		reg_write(PCR, 32'h00001008);
		reg_write(XCR, 32'h00000008);
		chk_wr = 1'b1;
		bus_op(0, 1'b1, 1'b0, 24'hFFFF81, 32'hA5C30F96, q0, l0);
		bus_op(1, 1'b1, 1'b0, 24'h001F02, 32'h5A3CF069, q1, l1);
		chk_wr = 1'b0;
		bus_op(0, 1'b0, 1'b0, 24'hFFFF81, 32'h0, q0, l0);
		check_val(q0, 32'hA5C30F96);
		check_val(l0 - 2, 32'h3);
		// A read straight behind a write pays for the transition cycle.
		bus_op(1, 1'b1, 1'b0, 24'h001F03, 32'h0F0F1234, q1, l1);
		bus_op(1, 1'b0, 1'b0, 24'h001F03, 32'h0, q1, l1);
		check_val(q1, 32'h0F0F1234);
		check_val(l1 - 2, 32'h3);
		fork
			bus_op(0, 1'b0, 1'b0, 24'hFFFF81, 32'h0, q0, l0);
			bus_op(1, 1'b0, 1'b0, 24'h001F02, 32'h0, q1, l1);
		join
		check_val(q1, 32'h5A3CF069);
		check_val({l0[7:0], l1[7:0]}, 32'h0404);
		// The same address in I/O space must not touch memory.
		bus_op(1, 1'b1, 1'b1, 24'h001F02, 32'hC3C30001, q1, l1);
		bus_op(1, 1'b0, 1'b1, 24'h001F02, 32'h0, q1, l1);
		check_val(q1, 32'hC3C30001);
		bus_op(1, 1'b0, 1'b0, 24'h001F02, 32'h0, q1, l1);
		check_val(q1, 32'h5A3CF069);
		for (int i = 0; i < 7; i++)
		begin
			slow_p = WT[i][5];
			reg_write(PCR, {19'h0, 5'h10, WT[i][10:6], 3'h0});
			bus_op(0, 1'b0, 1'b0, 24'hFFFF81, 32'h0, q0, l0);
			ok = WT[i][4] ? (l0 - 2 >= WT[i][3:0]) : (l0 - 2 == WT[i][3:0]);
			check_val(ok, 1'h1);
			check_val(q0, 32'hA5C30F96);
		end
		slow_p = 1'b0;
		// Software hold is acknowledged even while the hold pin is masked.
		reg_write(PCR, 32'h0000100E);
		wait_ack(1'b0);
		check_val({held_status, prim_ctrl_oe_n}, 2'h3);
		reg_check(PCR, 32'h0000100F);
		reg_write(PCR, 32'h0000100A);
		wait_ack(1'b1);
		hold_req_n = 1'b0;
		repeat (10) @(posedge clk);
		#1;
		check_val(bus_release_ack_n, 1'h1);
		reg_write(PCR, 32'h00001008);
		wait_ack(1'b0);
		reg_check(PCR, 32'h00001009);
		bus_op(1, 1'b0, 1'b0, 24'h001F02, 32'h0, q1, l1);
		check_val(q1, 32'h5A3CF069);
		hold_req_n = 1'b1;
		wait_ack(1'b1);
		reg_check(PCR, 32'h00001008);
		report_and_stop();
	end
endmodule : external_bus_interface_tb_top

// [verilog/ebi_core.sv]
`timescale 1ns/10ps
module ebi_core (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// Control register port
	input  wire logic                        reg_wr,
	input  wire logic [23:0]                 reg_addr,
	input  wire logic [31:0]                 reg_wdata,
	output logic      [31:0]                 reg_rdata,
	// CPU and DMA requests, index 0 primary, 1 expansion
	input  wire ebi_pkg::ebi_req_t [1:0]     req,
	output logic      [1:0]                  req_ready,
	output logic      [1:0]                  rd_valid,
	output logic      [1:0][31:0]            rd_data,
	// Primary bus pins
	output logic                             primary_access_strobe_n,
	output logic                             prim_rw,
	output logic      [ebi_pkg::EBI_PAW-1:0] prim_addr,
	output logic      [ebi_pkg::EBI_DW-1:0]  prim_data_out,
	input  wire logic [ebi_pkg::EBI_DW-1:0]  prim_data_in,
	output logic                             prim_data_oe_n,
	output logic                             prim_ctrl_oe_n,
	input  wire logic                        prim_ready_n,
	// Expansion bus pins
	output logic                             expansion_memory_strobe_n,
	output logic                             expansion_io_strobe_n,
	output logic                             exp_rw,
	output logic      [ebi_pkg::EBI_XAW-1:0] exp_addr,
	output logic      [ebi_pkg::EBI_DW-1:0]  exp_data_out,
	input  wire logic [ebi_pkg::EBI_DW-1:0]  exp_data_in,
	output logic                             exp_data_oe_n,
	input  wire logic                        expansion_ready_n,
	// Bus hold
	input  wire logic                        hold_req_n,
	output logic                             bus_release_ack_n,
	output logic                             held_status
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Pin synchronisers.
	logic [1:0][31:0] din_meta_ff;
	logic [1:0][31:0] din_sync_ff;
	logic [1:0]       rdy_meta_ff;
	logic [1:0]       rdy_sync_ff;
	logic             hold_meta_ff;
	logic             hold_sync_ff;

	// Control register fields, index 0 primary, 1 expansion.
	logic             external_hold_disable_ff;
	logic             float_ff;
	logic [1:0][1:0]  mode_ff;
	logic [1:0][2:0]  count_ff;
	logic [4:0]       bank_ff;
	logic [31:0]      rdata_ff;

	// Hold handling.
	logic             hold_want;
	logic             gap_ff;
	logic             bus_release_ack_n_ff;
	logic             prim_idle;

	// Builds a control word; reserved bits stay zero.
	function automatic logic [31:0] ebi_ctrl_word(
		input logic       held,
		input logic       external_hold_disable,
		input logic       flt,
		input logic [1:0] mode,
		input logic [2:0] count,
		input logic [4:0] bank
	);
		logic [31:0] w;
		w = '0;
		w[ebi_pkg::EBI_HELD_BIT]        = held;
		w[ebi_pkg::EBI_EXTERNAL_HOLD_DISABLE_BIT]      = external_hold_disable;
		w[ebi_pkg::EBI_FLOAT_BIT]       = flt;
		w[ebi_pkg::EBI_MODE_LSB +: 2]   = mode;
		w[ebi_pkg::EBI_COUNT_LSB +: 3]  = count;
		w[ebi_pkg::EBI_BANK_LSB +: 5]   = bank;
		return w;
	endfunction : ebi_ctrl_word

	// Every pin input passes two flops; data therefore lags the pins by two cycles.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			din_meta_ff  <= '0;
			din_sync_ff  <= '0;
			rdy_meta_ff  <= 2'h3;
			rdy_sync_ff  <= 2'h3;
			hold_meta_ff <= 1'b1;
			hold_sync_ff <= 1'b1;
		end
		else
		begin
			din_meta_ff  <= {exp_data_in, prim_data_in};
			din_sync_ff  <= din_meta_ff;
			rdy_meta_ff  <= {expansion_ready_n, prim_ready_n};
			rdy_sync_ff  <= rdy_meta_ff;
			hold_meta_ff <= hold_req_n;
			hold_sync_ff <= hold_meta_ff;
		end
	end

	// Register writes; the expansion register keeps only mode and count.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			external_hold_disable_ff <= 1'b0;
			float_ff  <= 1'b0;
			mode_ff   <= {2{ebi_pkg::EBI_MODE_RST}};
			count_ff  <= {2{ebi_pkg::EBI_COUNT_RST}};
			bank_ff   <= ebi_pkg::EBI_BANK_RST;
		end
		else if (reg_wr && reg_addr == ebi_pkg::EBI_PRIM_CTRL_ADDR)
		begin
			external_hold_disable_ff   <= reg_wdata[ebi_pkg::EBI_EXTERNAL_HOLD_DISABLE_BIT];
			float_ff    <= reg_wdata[ebi_pkg::EBI_FLOAT_BIT];
			mode_ff[0]  <= reg_wdata[ebi_pkg::EBI_MODE_LSB +: 2];
			count_ff[0] <= reg_wdata[ebi_pkg::EBI_COUNT_LSB +: 3];
			bank_ff     <= reg_wdata[ebi_pkg::EBI_BANK_LSB +: 5];
		end
		else if (reg_wr && reg_addr == ebi_pkg::EBI_EXP_CTRL_ADDR)
		begin
			mode_ff[1]  <= reg_wdata[ebi_pkg::EBI_MODE_LSB +: 2];
			count_ff[1] <= reg_wdata[ebi_pkg::EBI_COUNT_LSB +: 3];
		end
	end

	// Read data follows the address one cycle later; unmapped addresses read zero.
	always_ff @(posedge clk)
	begin
		if (reset)
			rdata_ff <= '0;
		else if (reg_addr == ebi_pkg::EBI_PRIM_CTRL_ADDR)
			rdata_ff <= ebi_ctrl_word(bus_release_ack_n_ff, external_hold_disable_ff, float_ff, mode_ff[0], count_ff[0], bank_ff);
		else if (reg_addr == ebi_pkg::EBI_EXP_CTRL_ADDR)
			rdata_ff <= ebi_ctrl_word(1'b0, 1'b0, 1'b0, mode_ff[1], count_ff[1], 5'h00);
		else
			rdata_ff <= '0;
	end

	assign reg_rdata = rdata_ff;

	// Software hold always counts; the pin only when not disabled.
	assign hold_want = (!hold_sync_ff && !external_hold_disable_ff) || float_ff;

	// One idle cycle must pass before the acknowledge, so a strobe never meets a float.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			gap_ff   <= 1'b0;
			bus_release_ack_n_ff <= 1'b0;
		end
		else
		begin
			gap_ff   <= hold_want && prim_idle && !bus_release_ack_n_ff;
			bus_release_ack_n_ff <= hold_want && prim_idle && (gap_ff || bus_release_ack_n_ff);
		end
	end

	assign bus_release_ack_n = !bus_release_ack_n_ff;
	assign held_status       = bus_release_ack_n_ff;
	assign prim_ctrl_oe_n    = bus_release_ack_n_ff;

	// One engine per bus; they share nothing, so both may run at once.
	for (genvar i = 0; i < 2; i++)
	begin : g_bus
		ebi_pkg::ebi_state_t state_ff;
		ebi_pkg::ebi_state_t nxt_state;
		ebi_pkg::ebi_pins_t  pins_ff;
		logic                doe_n_ff;
		logic                rdv_ff;
		logic [1:0]          cap_ff;
		logic [31:0]         rdd_ff;
		logic                last_wr_ff;
		logic                cur_wr_ff;
		logic                cur_io_ff;
		logic                req_io;
		logic                nxt_io;
		logic                nxt_wr;
		logic                gate;
		logic                done;
		logic                take;
		logic                lead;
		logic                start;
		logic                int_rdy_n;

		// The primary bus stops taking work as soon as a hold is wanted.
		assign gate      = (i == ebi_pkg::EBI_PRIM) ? !(hold_want || bus_release_ack_n_ff) : 1'b1;
		assign req_io    = (i == ebi_pkg::EBI_EXP) && req[i].io;
		assign done      = (state_ff == ebi_pkg::EBI_ACTIVE) && !int_rdy_n;
		assign req_ready[i] = gate && (state_ff == ebi_pkg::EBI_IDLE || (done && !cur_io_ff));
		assign take      = req[i].valid && req_ready[i];
		assign lead      = !req_io && (req[i].write || last_wr_ff);
		assign start     = (take && !lead) || state_ff == ebi_pkg::EBI_LEAD;
		assign nxt_io    = take ? req_io : cur_io_ff;
		assign nxt_wr    = take ? req[i].write : cur_wr_ff;

		// Each state lasts whole clock periods; back-to-back memory reads keep the strobe low.
		always_comb
		begin
			nxt_state = state_ff;
			case (state_ff)
				ebi_pkg::EBI_IDLE:
					if (take)
						nxt_state = lead ? ebi_pkg::EBI_LEAD : ebi_pkg::EBI_ACTIVE;
				ebi_pkg::EBI_LEAD:
					nxt_state = ebi_pkg::EBI_ACTIVE;
				ebi_pkg::EBI_ACTIVE:
					if (done && cur_io_ff)
						nxt_state = ebi_pkg::EBI_TRAIL;
					else if (done && take)
						nxt_state = lead ? ebi_pkg::EBI_LEAD : ebi_pkg::EBI_ACTIVE;
					else if (done)
						nxt_state = ebi_pkg::EBI_IDLE;
				default:
					nxt_state = ebi_pkg::EBI_IDLE;
			endcase
		end

		// Access context is captured when the request is taken.
		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				state_ff   <= ebi_pkg::EBI_IDLE;
				last_wr_ff <= 1'b0;
				cur_wr_ff  <= 1'b0;
				cur_io_ff  <= 1'b0;
			end
			else
			begin
				state_ff <= nxt_state;
				if (take)
				begin
					last_wr_ff <= req[i].write;
					cur_wr_ff  <= req[i].write;
					cur_io_ff  <= req_io;
				end
			end
		end

		// Strobes come straight from the next state; select and address move only on a take.
		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				pins_ff  <= '{strobe_n: 1'b1, io_strobe_n: 1'b1, rw: 1'b1, addr: '0, data: '0};
				doe_n_ff <= 1'b1;
			end
			else
			begin
				pins_ff.strobe_n    <= !(nxt_state == ebi_pkg::EBI_ACTIVE && !nxt_io);
				pins_ff.io_strobe_n <= !(nxt_state == ebi_pkg::EBI_ACTIVE && nxt_io);
				if (take)
				begin
					pins_ff.rw   <= !req[i].write;
					pins_ff.addr <= req[i].addr;
					pins_ff.data <= req[i].data;
				end
				doe_n_ff <= !(nxt_wr && nxt_state != ebi_pkg::EBI_IDLE);
			end
		end

		// Read data is the word seen in the last active cycle, as late as the access allows.
		// The two capture stages wait out the pin synchroniser; taking the word at the done edge would
		// pick up the bus as it stood two cycles earlier, before the strobe of a zero-wait access went low.
		always_ff @(posedge clk)
		begin
			if (reset)
			begin
				cap_ff <= '0;
				rdv_ff <= 1'b0;
				rdd_ff <= '0;
			end
			else
			begin
				cap_ff <= {cap_ff[0], done && !cur_wr_ff};
				rdv_ff <= cap_ff[1];
				if (cap_ff[1])
					rdd_ff <= din_sync_ff[i];
			end
		end

		ebi_wait #(
			.CW(ebi_pkg::EBI_CW)
		) u_wait (
			.clk              (clk),
			.reset            (reset),
			.start            (start),
			.count            (count_ff[i]),
			.mode             (ebi_pkg::ebi_wmode_t'(mode_ff[i])),
			.ext_ready_n      (rdy_sync_ff[i]),
			.counter_ready_n  (),
			.internal_ready_n (int_rdy_n)
		);
	end

	assign prim_idle = (g_bus[0].state_ff == ebi_pkg::EBI_IDLE);

	// Primary pins; data floats during hold as well as when not writing.
	assign primary_access_strobe_n = g_bus[0].pins_ff.strobe_n;
	assign prim_rw                 = g_bus[0].pins_ff.rw;
	assign prim_addr               = g_bus[0].pins_ff.addr;
	assign prim_data_out           = g_bus[0].pins_ff.data;
	assign prim_data_oe_n          = g_bus[0].doe_n_ff | bus_release_ack_n_ff;

	// Expansion pins carry only the low address bits.
	assign expansion_memory_strobe_n = g_bus[1].pins_ff.strobe_n;
	assign expansion_io_strobe_n     = g_bus[1].pins_ff.io_strobe_n;
	assign exp_rw                    = g_bus[1].pins_ff.rw;
	assign exp_addr                  = g_bus[1].pins_ff.addr[ebi_pkg::EBI_XAW-1:0];
	assign exp_data_out              = g_bus[1].pins_ff.data;
	assign exp_data_oe_n             = g_bus[1].doe_n_ff;

	assign rd_valid = {g_bus[1].rdv_ff, g_bus[0].rdv_ff};
	assign rd_data  = {g_bus[1].rdd_ff, g_bus[0].rdd_ff};

	chk_strobes_exclusive: assert property (
		!(!expansion_memory_strobe_n && !expansion_io_strobe_n))
		else $error("Expansion strobes low together.");

	chk_fields_reset: assert property (
		$past(reset) |-> mode_ff == {2{ebi_pkg::EBI_MODE_RST}} && count_ff == {2{ebi_pkg::EBI_COUNT_RST}}
			&& bank_ff == ebi_pkg::EBI_BANK_RST)
		else $error("Control fields wrong after reset.");

	chk_external_hold_disable_ignores: assert property (
		(external_hold_disable_ff && !float_ff)[*2] |-> bus_release_ack_n)
		else $error("Hold acknowledged while external hold disabled.");

	chk_float_acked: assert property (
		(float_ff && prim_idle)[*3] |-> !bus_release_ack_n && held_status)
		else $error("Software hold not acknowledged.");

	chk_held_float: assert property (
		!bus_release_ack_n |-> prim_ctrl_oe_n && prim_data_oe_n && $past(prim_idle))
		else $error("Primary port driven during hold.");

	chk_hold_gap: assert property (
		$fell(bus_release_ack_n) |-> $past(prim_idle, 2) && $past(hold_want, 2))
		else $error("Hold acknowledged without an idle gap.");

	chk_zero_wait_read: assert property (
		g_bus[0].take && !req[0].write && !g_bus[0].last_wr_ff && count_ff[0] == 3'h0
			&& mode_ff[0] == ebi_pkg::EBI_WM_CNT
		|=> !primary_access_strobe_n ##3 rd_valid[0])
		else $error("Zero-wait read not one cycle.");

	chk_write_lead: assert property (
		g_bus[0].take && req[0].write |=> primary_access_strobe_n && !prim_data_oe_n
			##1 !primary_access_strobe_n && !prim_rw)
		else $error("Write lacks a strobe-high transition cycle.");

	chk_read_after_write: assert property (
		g_bus[1].take && !req[1].write && !req[1].io && g_bus[1].last_wr_ff
		|=> expansion_memory_strobe_n ##1 !expansion_memory_strobe_n)
		else $error("Read after write not stretched.");

	chk_held_during_strobe: assert property (
		!primary_access_strobe_n && $past(!primary_access_strobe_n) && $past(g_bus[0].int_rdy_n)
		|-> $stable(prim_rw) && $stable(prim_addr))
		else $error("Select or address moved during an extended access.");

	chk_io_trail: assert property (
		!expansion_io_strobe_n ##1 expansion_io_strobe_n |-> exp_rw == $past(exp_rw))
		else $error("Select changed with I/O strobe.");
endmodule : ebi_core

// [verilog/ebi_pkg.sv]
package ebi_pkg;
	localparam int EBI_DW  = 32;
	localparam int EBI_PAW = 24;
	localparam int EBI_XAW = 13;
	localparam int EBI_CW  = 3;
	localparam int EBI_PRIM = 0;
	localparam int EBI_EXP  = 1;

	localparam logic [23:0] EBI_EXP_CTRL_ADDR  = 24'h808060;
	localparam logic [23:0] EBI_PRIM_CTRL_ADDR = 24'h808064;

	localparam int EBI_HELD_BIT   = 0;
	localparam int EBI_EXTERNAL_HOLD_DISABLE_BIT = 1;
	localparam int EBI_FLOAT_BIT  = 2;
	localparam int EBI_MODE_LSB   = 3;
	localparam int EBI_COUNT_LSB  = 5;
	localparam int EBI_BANK_LSB   = 8;

	localparam logic [1:0] EBI_MODE_RST  = 2'h3;
	localparam logic [2:0] EBI_COUNT_RST = 3'h7;
	localparam logic [4:0] EBI_BANK_RST  = 5'h10;

	typedef enum logic [1:0] {
		EBI_WM_EXT  = 2'h0,
		EBI_WM_CNT  = 2'h1,
		EBI_WM_ANY  = 2'h2,
		EBI_WM_BOTH = 2'h3
	} ebi_wmode_t;

	typedef enum logic [1:0] {
		EBI_IDLE   = 2'h0,
		EBI_LEAD   = 2'h1,
		EBI_ACTIVE = 2'h3,
		EBI_TRAIL  = 2'h2
	} ebi_state_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        io;
		logic [23:0] addr;
		logic [31:0] data;
	} ebi_req_t;

	typedef struct packed {
		logic        strobe_n;
		logic        io_strobe_n;
		logic        rw;
		logic [23:0] addr;
		logic [31:0] data;
	} ebi_pins_t;
endpackage : ebi_pkg

// [verilog/ebi_wait.sv]
`timescale 1ns/10ps
module ebi_wait #(
	parameter int CW = 3
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// Access start and settings
	input  wire logic               start,
	input  wire logic [CW-1:0]      count,
	input  wire ebi_pkg::ebi_wmode_t mode,
	// Ready terms
	input  wire logic               ext_ready_n,
	output logic                    counter_ready_n,
	output logic                    internal_ready_n
);
	logic [CW-1:0]       cnt_ff;
	ebi_pkg::ebi_wmode_t mode_ff;

	// Settings are caught at access start so a register write never bends a running access.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt_ff  <= '0;
			mode_ff <= ebi_pkg::EBI_WM_BOTH;
		end
		else if (start)
		begin
			cnt_ff  <= count;
			mode_ff <= mode;
		end
		else if (cnt_ff != '0)
			cnt_ff <= cnt_ff - 1'b1;
	end

	assign counter_ready_n = (cnt_ff != '0);

	// Ready terms are active low, so a logical OR is an AND of the wires.
	always_comb
	begin
		case (mode_ff)
			ebi_pkg::EBI_WM_EXT: internal_ready_n = ext_ready_n;
			ebi_pkg::EBI_WM_CNT: internal_ready_n = counter_ready_n;
			ebi_pkg::EBI_WM_ANY: internal_ready_n = ext_ready_n & counter_ready_n;
			default:             internal_ready_n = ext_ready_n | counter_ready_n;
		endcase
	end

	chk_count_load: assert property (@(posedge clk) disable iff (reset)
		start |=> (counter_ready_n == ($past(count) != '0)))
		else $error("Wait counter did not load the count.");
endmodule : ebi_wait
